// >>> rtl/spsc_consts.svh
// Offsets, field positions, reset values and timings in ns for the slave port control block
`ifndef SPSC_CONSTS_SVH
`define SPSC_CONSTS_SVH
// Register offsets (byte addresses on the plain register port)
`define SPSC_OFF_CTRL 8'h23
`define SPSC_OFF_WFLAG0 8'h24
`define SPSC_OFF_RFLAG0 8'h28
`define SPSC_OFF_IRQ_STAT 8'h30
`define SPSC_OFF_IRQ_MASK 8'h31
// Control register field positions
`define SPSC_BIT_EN 7
`define SPSC_BIT_PSEL 6
`define SPSC_BIT_ACT_CLR 5
`define SPSC_BIT_STOP_EN 4
`define SPSC_BIT_RIE 3
`define SPSC_BIT_WIE 2
// Reset values
`define SPSC_CTRL_RST 8'h00
`define SPSC_MASK_RST 8'h00
// Wake-up codes
`define SPSC_WUP_PACKET 2'h0
`define SPSC_WUP_MB15 2'h1
`define SPSC_WUP_MB31 2'h2
`define SPSC_MB15 5'h0f
`define SPSC_MB31 5'h1f
// Boot strap sampling delay after reset release, in ns
`define SPSC_BOOT_NS 100
`define SPSC_CLK_NS 25
`endif

// >>> rtl/spsc_pkg.sv
// Types shared by the slave port control block
package spsc_pkg;
  // Boot sequence states, Gray coded along the path
  typedef enum logic [1:0] {
    SPSC_BOOT_WAIT = 2'b00,
    SPSC_BOOT_SAMPLE = 2'b01,
    SPSC_BOOT_DONE = 2'b11
  } spsc_boot_e;
  typedef logic [7:0] spsc_byte_t;
endpackage : spsc_pkg

// >>> rtl/spsc_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module spsc_sync (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic async_in, // Level from outside
  output logic sync_out // Synchronised level
);
  logic meta_r; // First stage, read only by the second
  ////////////////////////////////////////////////////////////////
  // Two stages; constant reset values only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : spsc_sync

// >>> rtl/spsc_flags.sv
// Thirty-two sticky per-mailbox flags with set and clear
`timescale 1ns/1ps
module spsc_flags #(
  parameter int NUM_MB = 32 // Mailbox count
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic hit, // One access pulse
  input wire logic [4:0] hit_idx, // Mailbox index of the access
  input wire logic clr, // Clear all flags
  output logic [NUM_MB-1:0] flags // Sticky flags, bit n is mailbox n
);
  ////////////////////////////////////////////////////////////////
  // Set wins over clear so a racing access is never lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      for (int i = 0; i < NUM_MB; i++) begin
        if (hit && (hit_idx == 5'(i))) begin
          flags[i] <= 1'b1;
        end else if (clr) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end
endmodule : spsc_flags

// >>> rtl/spsc_ctrl.sv
// Slave port status and control register, mailbox flags and interrupts
//
// Behaviour
// - Enable bit gates port; select picks interface
// - Select bit 6: 0 I2C, 1 SPI
// - Boot strap low sets select to SPI
// - Single-interface variant makes select read-only
// - Bit 5 reads port-active; meaningless when disabled
// - Writing clear bit clears all status flags; the code clears mailbox flags and pending only, event status stays
// - Stop enable 0 defers interrupts until wake
// - Read enable interrupts on host mailbox read
// - Write enable interrupts on host mailbox write
// - Clear bit also clears pending mailbox interrupts
// - Write flags track each mailbox separately
// - Wakeup code picks packet end, mailbox 15, 31
// - Thirty-two write flags, flag n is mailbox n
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "spsc_consts.svh"
module spsc_ctrl import spsc_pkg::*; #(
  parameter bit HAS_SPI = 1'b1, // Variant implements the SPI slave
  parameter bit HAS_I2C = 1'b1, // Variant implements the I2C slave
  parameter int NUM_MB = 32 // Mailbox count
) (
  input wire logic ref_clk, // System clock, 40 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic boot_select_pin, // Boot strap pin, asynchronous
  input wire logic link_clk, // Serial link clock, asynchronous
  input wire logic link_busy, // Link engine sees bus traffic
  input wire logic mb_wr, // Host wrote a mailbox (pulse)
  input wire logic mb_rd, // Host read a mailbox (pulse)
  input wire logic [4:0] mb_idx, // Mailbox index of the access
  input wire logic pkt_end, // End of host packet (pulse)
  input wire logic stop_mode, // Device in STOP mode
  output logic port_enable, // Slave port enabled
  output logic port_select, // 1 SPI, 0 I2C
  output logic spi_enable, // SPI engine enabled
  output logic i2c_enable, // I2C engine enabled
  output logic mbox_irq, // Mailbox interrupt to the CPU
  output logic irq // Summary interrupt, masked status
);
  localparam int BOOT_CYC = (`SPSC_BOOT_NS + `SPSC_CLK_NS - 1) / `SPSC_CLK_NS; // Round up
  ////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic boot_pin_s; // Strap after two flops
  logic link_clk_s; // Link clock after two flops
  logic link_clk_d; // Previous link clock sample
  logic link_edge; // Rising link edge seen
  logic busy_s; // Bus activity after two flops
  spsc_sync u_sync_boot (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(boot_select_pin),
                         .sync_out(boot_pin_s));
  spsc_sync u_sync_lclk (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(link_clk),
                         .sync_out(link_clk_s));
  spsc_sync u_sync_busy (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(link_busy),
                         .sync_out(busy_s));
  // Edge detector on the synchronised link clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
    end
  end
  assign link_edge = link_clk_s && !link_clk_d;
  ////////////////////////////////////////////////////////////////
  // Decode
  logic wr_ctrl; // Write to control register
  logic csr_wr; // Clear-status strobe written
  logic rd_stat; // Read of interrupt status
  assign wr_ctrl = reg_wr && (reg_addr == `SPSC_OFF_CTRL);
  assign csr_wr = wr_ctrl && reg_wdata[`SPSC_BIT_ACT_CLR];
  assign rd_stat = reg_rd && (reg_addr == `SPSC_OFF_IRQ_STAT);
  ////////////////////////////////////////////////////////////////
  // Boot sequence: sample strap after release, once per reset
  spsc_boot_e boot_r; // Boot state
  logic [7:0] boot_cnt_r; // Wait counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_r <= SPSC_BOOT_WAIT;
      boot_cnt_r <= 8'h00;
    end else begin
      unique case (boot_r)
        SPSC_BOOT_WAIT: begin
          boot_cnt_r <= boot_cnt_r + 8'h01;
          if (boot_cnt_r == 8'(BOOT_CYC)) begin
            boot_r <= SPSC_BOOT_SAMPLE;
          end
        end
        SPSC_BOOT_SAMPLE: begin
          boot_r <= SPSC_BOOT_DONE;
        end
        SPSC_BOOT_DONE: begin
          boot_r <= SPSC_BOOT_DONE;
        end
        default: begin
          boot_r <= SPSC_BOOT_WAIT;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // Control fields
  logic stop_en_r; // Interrupts allowed in STOP
  logic rie_r; // Read interrupt enable
  logic wie_r; // Write interrupt enable
  logic [1:0] wakeup_config_r; // Wake-up configuration
  // Enable and select; select is fixed on single-interface variants
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_enable <= 1'b0;
      port_select <= 1'b0;
    end else begin
      if (boot_r == SPSC_BOOT_SAMPLE) begin
        // Strap low means SPI, otherwise I2C
        port_select <= (HAS_SPI && !HAS_I2C) ? 1'b1 :
                       (HAS_I2C && !HAS_SPI) ? 1'b0 : !boot_pin_s;
      end else if (wr_ctrl) begin
        port_enable <= reg_wdata[`SPSC_BIT_EN];
        // Select only moves while disabled, so a live link is not torn down
        if (HAS_SPI && HAS_I2C && !port_enable) begin
          port_select <= reg_wdata[`SPSC_BIT_PSEL];
        end
      end
    end
  end
  // Interrupt and wake-up fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_en_r <= 1'b0;
      rie_r <= 1'b0;
      wie_r <= 1'b0;
      wakeup_config_r <= 2'h0;
    end else if (wr_ctrl) begin
      stop_en_r <= reg_wdata[`SPSC_BIT_STOP_EN];
      rie_r <= reg_wdata[`SPSC_BIT_RIE];
      wie_r <= reg_wdata[`SPSC_BIT_WIE];
      wakeup_config_r <= reg_wdata[1:0];
    end
  end
  // Engine enables follow the select bit while enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_enable <= 1'b0;
      i2c_enable <= 1'b0;
    end else begin
      spi_enable <= port_enable && port_select;
      i2c_enable <= port_enable && !port_select;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Port activity: link edges for SPI, bus busy for I2C
  logic active_r; // Port-active indication
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
    end else begin
      active_r <= port_select ? (link_edge || (active_r && busy_s)) : busy_s;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Mailbox flags; accesses only count while the port is enabled
  logic [NUM_MB-1:0] wflags; // Write flags
  logic [NUM_MB-1:0] rflags; // Read flags
  spsc_flags #(.NUM_MB(NUM_MB)) u_wflags (.ref_clk(ref_clk), .rst_n(rst_n),
    .hit(mb_wr && port_enable), .hit_idx(mb_idx), .clr(csr_wr), .flags(wflags));
  spsc_flags #(.NUM_MB(NUM_MB)) u_rflags (.ref_clk(ref_clk), .rst_n(rst_n),
    .hit(mb_rd && port_enable), .hit_idx(mb_idx), .clr(csr_wr), .flags(rflags));
  ////////////////////////////////////////////////////////////////
  // Wake-up qualified interrupt events
  logic seen_wr_r; // Write in current packet
  logic seen_rd_r; // Read in current packet
  logic ev_wr; // Qualified write event
  logic ev_rd; // Qualified read event
  logic mb_hit_sel; // Access to the selected wake mailbox
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_wr_r <= 1'b0;
      seen_rd_r <= 1'b0;
    end else if (pkt_end) begin
      seen_wr_r <= 1'b0;
      seen_rd_r <= 1'b0;
    end else begin
      seen_wr_r <= seen_wr_r || (mb_wr && port_enable);
      seen_rd_r <= seen_rd_r || (mb_rd && port_enable);
    end
  end
  always_comb begin
    mb_hit_sel = 1'b0;
    ev_wr = 1'b0;
    ev_rd = 1'b0;
    unique case (wakeup_config_r)
      `SPSC_WUP_PACKET: begin
        // One event per packet however many mailboxes it touched
        // An access in the packet-end cycle still belongs to that packet
        ev_wr = pkt_end && (seen_wr_r || (mb_wr && port_enable));
        ev_rd = pkt_end && (seen_rd_r || (mb_rd && port_enable));
      end
      `SPSC_WUP_MB15: begin
        mb_hit_sel = (mb_idx == `SPSC_MB15);
        ev_wr = mb_wr && port_enable && mb_hit_sel;
        ev_rd = mb_rd && port_enable && mb_hit_sel;
      end
      `SPSC_WUP_MB31: begin
        mb_hit_sel = (mb_idx == `SPSC_MB31);
        ev_wr = mb_wr && port_enable && mb_hit_sel;
        ev_rd = mb_rd && port_enable && mb_hit_sel;
      end
      default: begin
        // Reserved code raises nothing
        mb_hit_sel = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Pending mailbox interrupts; set wins over the clear strobe
  logic pend_wr_r; // Pending write interrupt
  logic pend_rd_r; // Pending read interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_wr_r <= 1'b0;
      pend_rd_r <= 1'b0;
    end else begin
      if (ev_wr && wie_r) begin
        pend_wr_r <= 1'b1;
      end else if (csr_wr) begin
        pend_wr_r <= 1'b0;
      end
      if (ev_rd && rie_r) begin
        pend_rd_r <= 1'b1;
      end else if (csr_wr) begin
        pend_rd_r <= 1'b0;
      end
    end
  end
  // Output deferred in STOP unless stop enable is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mbox_irq <= 1'b0;
    end else begin
      mbox_irq <= (pend_wr_r || pend_rd_r) && (!stop_mode || stop_en_r);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Sticky status: bit0 write event, bit1 read event; read clears
  logic [1:0] irq_stat_r; // Sticky event status
  logic [1:0] irq_mask_r; // Interrupt mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      // A new event in the read cycle survives the clear
      irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r) | {ev_rd, ev_wr};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= 2'h0;
    end else if (reg_wr && (reg_addr == `SPSC_OFF_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata[1:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_stat ? 2'h0 : irq_stat_r) | {ev_rd, ev_wr}) & irq_mask_r);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Read mux; clear-status bit reads as active, never as 1 written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SPSC_OFF_CTRL: reg_rdata <= {port_enable, port_select, active_r && port_enable,
                                      stop_en_r, rie_r, wie_r, wakeup_config_r};
        8'h24: reg_rdata <= wflags[31:24];
        8'h25: reg_rdata <= wflags[23:16];
        8'h26: reg_rdata <= wflags[15:8];
        8'h27: reg_rdata <= wflags[7:0];
        8'h28: reg_rdata <= rflags[31:24];
        8'h29: reg_rdata <= rflags[23:16];
        8'h2a: reg_rdata <= rflags[15:8];
        8'h2b: reg_rdata <= rflags[7:0];
        `SPSC_OFF_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_r};
        `SPSC_OFF_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Checks
  chk_engine_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    spi_enable |-> (port_enable || $past(port_enable)) && !i2c_enable)
    else $error("engine enables inconsistent");
  chk_sel_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && port_enable && boot_r == SPSC_BOOT_DONE) |=> $stable(port_select))
    else $error("select moved while enabled");
  chk_boot_strap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (boot_r == SPSC_BOOT_SAMPLE && HAS_SPI && HAS_I2C) |=> port_select == !$past(boot_pin_s))
    else $error("strap not applied");
  chk_csr_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (csr_wr && !mb_wr && !mb_rd) |=> (wflags == '0) && (rflags == '0))
    else $error("flags not cleared");
  chk_csr_readz: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `SPSC_OFF_CTRL && !port_enable) |=> !reg_rdata[5])
    else $error("bit 5 reads one while disabled");
  chk_stop_defer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (stop_mode && !stop_en_r) |=> !mbox_irq)
    else $error("interrupt raised in stop");
  chk_wr_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ev_wr && wie_r) |=> pend_wr_r)
    else $error("write interrupt not pending");
  chk_pend_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (csr_wr && !ev_rd && !ev_wr) |=> !pend_rd_r && !pend_wr_r)
    else $error("pending not cleared");
  chk_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mb_wr && port_enable) |=> wflags[$past(mb_idx)])
    else $error("write flag not set");
endmodule : spsc_ctrl

// >>> dv/spsc_host_model.sv
// Behavioural host controller that drives mailbox traffic into the slave port block
`timescale 1ns/1ps
module spsc_host_model (
  input wire logic ref_clk, // System clock
  output logic link_clk, // Serial clock, still outside frames
  output logic link_busy, // Bus traffic level
  output logic mb_wr, // Mailbox write pulse
  output logic mb_rd, // Mailbox read pulse
  output logic [4:0] mb_idx, // Mailbox index
  output logic pkt_end // End of packet pulse
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus: clock low, no strobes
  initial begin
    link_clk = 1'b0;
    link_busy = 1'b0;
    mb_wr = 1'b0;
    mb_rd = 1'b0;
    mb_idx = 5'h00;
    pkt_end = 1'b0;
  end
  // Hold the bus busy level by hand
  task automatic hold(input logic b);
    @(posedge ref_clk);
    link_busy <= b;
  endtask : hold
  // One packet of n accesses to consecutive mailboxes
  task automatic frame(input logic is_wr, input logic [4:0] first, input int n);
    logic [4:0] idx;
    idx = first;
    @(posedge ref_clk);
    link_busy <= 1'b1;
    for (int k = 0; k < n; k++) begin
      // Off-phase offset puts every link clock edge 13 ns after a ref_clk rising edge
      #13;
      repeat (16) begin
        #100 link_clk = ~link_clk;
      end
      @(posedge ref_clk);
      mb_idx <= idx;
      mb_wr <= is_wr;
      mb_rd <= !is_wr;
      @(posedge ref_clk);
      mb_wr <= 1'b0;
      mb_rd <= 1'b0;
      // Released index shows the inverse, never a stale match
      mb_idx <= ~idx;
      idx = idx + 5'h01;
    end
    @(posedge ref_clk);
    pkt_end <= 1'b1;
    @(posedge ref_clk);
    pkt_end <= 1'b0;
    link_busy <= 1'b0;
  endtask : frame
endmodule : spsc_host_model

// >>> dv/spsc_ctrl_tb.sv
// Self-checking bench for the slave port control register block
`timescale 1ns/1ps
module spsc_ctrl_tb;
  logic ref_clk, rst_n, reg_wr, reg_rd, boot_select_pin, stop_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic link_clk, link_busy, mb_wr, mb_rd, pkt_end;
  logic [4:0] mb_idx, first;
  logic port_enable, port_select, spi_enable, i2c_enable, mbox_irq, irq;
  logic [31:0] exp_wf;
  int miscompares, total_checks, cycles, n;
  ////////////////////////////////////////////////////////////////////////////////
  spsc_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_select_pin(boot_select_pin), .link_clk(link_clk), .link_busy(link_busy),
    .mb_wr(mb_wr), .mb_rd(mb_rd), .mb_idx(mb_idx), .pkt_end(pkt_end),
    .stop_mode(stop_mode), .port_enable(port_enable), .port_select(port_select),
    .spi_enable(spi_enable), .i2c_enable(i2c_enable), .mbox_irq(mbox_irq), .irq(irq));
  spsc_host_model i_host (.ref_clk(ref_clk), .link_clk(link_clk), .link_busy(link_busy),
    .mb_wr(mb_wr), .mb_rd(mb_rd), .mb_idx(mb_idx), .pkt_end(pkt_end));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per result width
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask : chk1
  // Let n edges pass, then sample settled outputs
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : tick
  // Register port cycles: one-cycle strobes, data in the cycle after a read
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // Expected flag word for n consecutive mailboxes, wrapping at 32
  function automatic logic [31:0] span(input logic [4:0] f, input int c);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int k = 0; k < c; k++) m[5'(f + 5'(k))] = 1'b1;
    return m;
  endfunction : span
  // Four flag bytes, highest mailboxes at the lowest offset
  task automatic chk_flags(input logic [7:0] base, input logic [31:0] e);
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      rd(base + 8'(i), v);
      chk8(v, e[31-8*i -: 8]);
    end
  endtask : chk_flags
  // Run one frame then allow the pending path to settle
  task automatic pkt(input logic w, input logic [4:0] f, input int c);
    i_host.frame(w, f, c);
    tick(4);
  endtask : pkt
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    boot_select_pin = 1'b0;
    stop_mode = 1'b0;
    void'($urandom(32'hba9d50a9));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(12);
    chk1(port_select, 1'b1);
    rd(8'h23, d);
    chk8(d, 8'h40);
    rd(8'h55, d);
    chk8(d, 8'h00);
    wr(8'h23, 8'h00);
    tick(1);
    chk1(port_select, 1'b0);
    chk1(spi_enable | i2c_enable, 1'b0);
    wr(8'h23, 8'h94);
    tick(1);
    chk1(i2c_enable, 1'b1);
    chk1(spi_enable, 1'b0);
    // Select change while enabled is refused
    wr(8'h23, 8'hd4);
    rd(8'h23, d);
    chk8(d & 8'hdf, 8'h94);
    // I2C activity shows in bit 5 while enabled
    i_host.hold(1'b1);
    tick(6);
    rd(8'h23, d);
    chk8(d, 8'hb4);
    i_host.hold(1'b0);
    tick(6);
    rd(8'h23, d);
    chk8(d, 8'h94);
    // Random burst of host writes, packet-end wake-up
    wr(8'h31, 8'h03);
    first = 5'($urandom());
    n = $urandom_range(1, 4);
    exp_wf = span(first, n);
    pkt(1'b1, first, n);
    chk1(mbox_irq, 1'b1);
    chk1(irq, 1'b1);
    chk_flags(8'h24, exp_wf);
    chk_flags(8'h28, 32'h0);
    rd(8'h30, d);
    chk8(d, 8'h01);
    tick(2);
    chk1(irq, 1'b0);
    rd(8'h31, d);
    chk8(d, 8'h03);
    wr(8'h23, 8'hb4);
    tick(2);
    chk1(mbox_irq, 1'b0);
    chk_flags(8'h24, 32'h0);
    // Read enable only: writes stay quiet, reads raise
    wr(8'h23, 8'h98);
    pkt(1'b1, 5'h07, 2);
    chk1(mbox_irq, 1'b0);
    rd(8'h30, d);
    chk8(d, 8'h01);
    // Read event alone under a write-only mask leaves irq low
    wr(8'h31, 8'h01);
    pkt(1'b0, 5'h1f, 2);
    chk1(mbox_irq, 1'b1);
    chk1(irq, 1'b0);
    chk_flags(8'h28, span(5'h1f, 2));
    chk_flags(8'h24, span(5'h07, 2));
    wr(8'h23, 8'hb8);
    rd(8'h30, d);
    chk8(d, 8'h02);
    tick(2);
    chk1(mbox_irq | irq, 1'b0);
    // Every other wake-up code in the low two bits
    for (int c = 1; c < 4; c++) begin
      wr(8'h23, 8'h94 | 8'(c));
      pkt(1'b1, 5'h0e, 1);
      chk1(mbox_irq, 1'b0);
      pkt(1'b1, 5'h0f, 1);
      chk1(mbox_irq, c == 1);
      wr(8'h23, 8'hb4 | 8'(c));
      pkt(1'b1, 5'h1f, 1);
      chk1(mbox_irq, c == 2);
      wr(8'h23, 8'hb4 | 8'(c));
    end
    rd(8'h30, d);
    // STOP handling with the stop enable off, then on
    wr(8'h23, 8'h84);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    pkt(1'b1, 5'h03, 1);
    chk1(mbox_irq, 1'b0);
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    tick(3);
    chk1(mbox_irq, 1'b1);
    wr(8'h23, 8'hb4);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    pkt(1'b1, 5'h03, 1);
    chk1(mbox_irq, 1'b1);
    stop_mode <= 1'b0;
    wr(8'h23, 8'h34);
    // Disabled port ignores traffic
    tick(1);
    chk1(i2c_enable, 1'b0);
    pkt(1'b1, 5'h05, 1);
    chk_flags(8'h24, 32'h0);
    rd(8'h30, d);
    // Switch to SPI while disabled, enable while idle
    wr(8'h23, 8'h54);
    wr(8'h23, 8'hd4);
    tick(1);
    chk1(spi_enable, 1'b1);
    chk1(i2c_enable, 1'b0);
    // SPI activity comes from link clock edges while the frame runs
    fork
      i_host.frame(1'b1, 5'h14, 1);
      begin
        tick(30);
        rd(8'h23, d);
        chk8(d, 8'hf4);
      end
    join
    tick(4);
    chk_flags(8'h24, span(5'h14, 1));
    // Second reset with the strap high boots to I2C
    @(posedge ref_clk);
    rst_n <= 1'b0;
    boot_select_pin <= 1'b1;
    tick(2);
    chk1(port_enable | mbox_irq | irq, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(12);
    chk1(port_select, 1'b0);
    rd(8'h23, d);
    chk8(d, 8'h00);
    end_sim();
  end
endmodule : spsc_ctrl_tb
